// File: config_overlay_checker.sv
`timescale 1ns/1ps
`include "config_overlay_defs.svh"
module config_overlay_checker (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             command_aborted_flag
);
  config_overlay_pkg::state_e state_r;
  logic        ap_wr_r;
  logic [7:0]  ap_addr_r;
  logic [31:0] hrdata_r;
  logic [8:0]  idx_r;
  logic [7:0]  sum_r;
  logic [15:0] w0_r;
  logic [15:0] w1_r;
  logic [15:0] w2_r;
  logic [15:0] w7_r;
  logic [15:0] w255_r;
  logic [47:0] wlba_r;
  logic [31:0] cfg_r;
  logic [2:0]  mw_r;
  logic [5:0]  udma_r;
  logic [8:0]  feat_r;
  logic [47:0] lba_r;
  logic        abort_r;
  logic        done_r;
  logic [7:0]  cyl_lo_r;
  logic [7:0]  cyl_hi_r;

  //----------------------------------------
  // ahb-lite slave decode
  //----------------------------------------
  wire        ap_take   = hsel & hready & htrans[1];
  wire        wr_ctrl   = ap_wr_r & (ap_addr_r == `OFF_CTRL);
  wire        wr_data   = ap_wr_r & (ap_addr_r == `OFF_DATA);
  wire        wr_cfg    = ap_wr_r & (ap_addr_r == `OFF_CFG);
  wire        start     = wr_ctrl & hwdata[`CTRL_START] &
                          (state_r == config_overlay_pkg::ST_IDLE);
  wire        rewind    = wr_ctrl & hwdata[`CTRL_REWIND];
  wire        word_in   = wr_data & (idx_r != `WORD_COUNT);
  wire [7:0]  byte_sum  = hwdata[7:0] + hwdata[15:8];
  wire        checking  = (state_r == config_overlay_pkg::ST_CHECK);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign command_aborted_flag = abort_r;

  //----------------------------------------
  // device state fields
  //----------------------------------------
  wire       supp     = cfg_r[`CFG_SUPP];
  wire       freeze   = cfg_r[`CFG_FREEZE];
  wire       hpa      = cfg_r[`CFG_HPA];
  wire       jumper   = cfg_r[`CFG_JUMPER];
  wire       sec_en   = cfg_r[`CFG_SEC];
  wire       smart_en = cfg_r[`CFG_SMART];
  wire       mw_sel_v = cfg_r[`CFG_MWSEL_V];
  wire       ud_sel_v = cfg_r[`CFG_UDSEL_V];
  wire [1:0] mw_sel   = cfg_r[9:8];
  wire [2:0] ud_sel   = cfg_r[14:12];

  //----------------------------------------
  // overlay checks
  //----------------------------------------
  // only bits reported now can be cleared
  wire [2:0]  clr1    = mw_r & ~w1_r[2:0];
  wire [5:0]  clr2    = udma_r & ~w2_r[5:0];
  wire [8:0]  clr7    = feat_r & ~w7_r[8:0];
  wire [2:0]  new_mw  = mw_r & ~clr1;
  wire [5:0]  new_ud  = udma_r & ~clr2;
  wire [8:0]  new_ft  = feat_r & ~clr7;
  wire [15:0] ill1;
  wire [15:0] ill2;
  wire [15:0] ill7;

  assign ill1[15:3] = 13'h0000;
  assign ill1[0]    = clr1[0];
  assign ill1[2]    = clr1[2] & mw_sel_v & (mw_sel == 2'h2);
  assign ill1[1]    = clr1[1] & (new_mw[2] | (mw_sel_v & (mw_sel != 2'h0)));

  assign ill2[15:6] = 10'h000;
  genvar n;
  generate
    for (n = 0; n < 6; n++) begin : g_udma
      // higher modes kept or mode n+ selected forbids the clear
      assign ill2[n] = clr2[n] & (((new_ud >> (n + 1)) != 6'h00) |
                                  (ud_sel_v & (ud_sel >= 3'(n))));
    end
  endgenerate

  assign ill7[15:9] = 7'h00;
  assign ill7[8]    = 1'b0;
  assign ill7[7]    = clr7[7] & hpa;
  assign ill7[6]    = 1'b0;
  assign ill7[5]    = 1'b0;
  assign ill7[4]    = clr7[4] & jumper;
  assign ill7[3]    = clr7[3] & sec_en;
  assign ill7[2]    = 1'b0;
  assign ill7[1]    = 1'b0;
  assign ill7[0]    = clr7[0] & ((new_ft[2:1] != 2'h0) | smart_en);

  wire lba_chg  = (wlba_r != lba_r);
  wire ill_lba  = lba_chg & (hpa | (wlba_r > `NATIVE_MAX));
  wire gate_bad = ~supp | freeze;
  wire fmt_bad  = (w0_r != `DCO_REV) |
                  (w255_r[7:0] != `DCO_SIG) |
                  (sum_r != 8'h00) |
                  (idx_r != `WORD_COUNT);
  wire any_ill  = (ill1 != 16'h0000) | (ill2 != 16'h0000) |
                  (ill7 != 16'h0000) | ill_lba;
  wire bad      = gate_bad | fmt_bad | any_ill;

  function automatic logic [7:0] low_bit(input logic [15:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 8'(i);
      end
    end
    return r;
  endfunction : low_bit

  // offender word and bit, lowest word first
  wire [7:0] off_word = (ill1 != 16'h0000) ? 8'h01 :
                        (ill2 != 16'h0000) ? 8'h02 :
                        ill_lba            ? 8'h03 : 8'h07;
  wire [7:0] off_bit  = (ill1 != 16'h0000) ? low_bit(ill1) :
                        (ill2 != 16'h0000) ? low_bit(ill2) :
                        ill_lba            ? 8'h00 : low_bit(ill7);
  wire       rep_loc  = ~gate_bad & ~fmt_bad & any_ill;

  //----------------------------------------
  // identify words
  //----------------------------------------
  wire [15:0] id63 = {13'h0000, mw_r};
  wire [15:0] id82 = {5'h00, feat_r[7], 8'h00, feat_r[3], feat_r[0]};
  wire [15:0] id83 = {5'h00, feat_r[8], feat_r[6], feat_r[7], 1'b0, feat_r[4], feat_r[4],
                      3'h0, feat_r[5], 1'b0};
  wire [15:0] id86 = {id83[15:10], 1'b0, id83[8:0]};
  wire [15:0] id84 = {14'h0000, feat_r[1], feat_r[2]};
  wire [15:0] id88 = {10'h000, udma_r};
  wire [15:0] id94 = (feat_r[6] & feat_r[4]) ? `ID94_VAL : 16'h0000;
  wire [47:0] lba48 = feat_r[8] ? lba_r : 48'h0;
  wire [47:0] lba28 = (lba_r > `LBA28_MAX) ? `LBA28_MAX : lba_r;

  wire [31:0] status = {8'h00, cyl_hi_r, cyl_lo_r, 5'h00, abort_r, done_r, checking};
  wire [7:0]  ra     = haddr[7:0];
  wire [31:0] rd_mux =
    (ra == `OFF_STATUS)  ? status :
    (ra == `OFF_CFG)     ? cfg_r :
    (ra == `OFF_ID63)    ? {16'h0000, id63} :
    (ra == `OFF_ID82_85) ? {id82, id82} :
    (ra == `OFF_ID83_86) ? {id86, id83} :
    (ra == `OFF_ID84_87) ? {id84, id84} :
    (ra == `OFF_ID88_94) ? {id94, id88} :
    (ra == `OFF_LBA_LO)  ? lba48[31:0] :
    (ra == `OFF_LBA_HI)  ? {16'h0000, lba48[47:32]} :
    (ra == `OFF_LBA28)   ? lba28[31:0] :
    (ra == `OFF_REV)     ? {16'h0000, `DCO_REV} : 32'h0000_0000;

  //----------------------------------------
  // bus phase registers
  //----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      ap_wr_r   <= ap_take & hwrite;
      ap_addr_r <= haddr[7:0];
      if (ap_take & ~hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  //----------------------------------------
  // overlay capture
  //----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_r  <= 9'h000;
      sum_r  <= 8'h00;
      w0_r   <= 16'h0000;
      w1_r   <= 16'h0000;
      w2_r   <= 16'h0000;
      w7_r   <= 16'h0000;
      w255_r <= 16'h0000;
      wlba_r <= 48'h0;
      cfg_r  <= `CFG_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_r <= hwdata;
      end
      if (rewind) begin
        idx_r <= 9'h000;
        sum_r <= 8'h00;
      end else if (word_in) begin
        idx_r <= idx_r + 9'h001;
        sum_r <= sum_r + byte_sum;
        case (idx_r)
          9'h000:  w0_r <= hwdata[15:0];
          9'h001:  w1_r <= hwdata[15:0];
          9'h002:  w2_r <= hwdata[15:0];
          9'h003:  wlba_r[15:0]  <= hwdata[15:0];
          9'h004:  wlba_r[31:16] <= hwdata[15:0];
          9'h005:  wlba_r[47:32] <= hwdata[15:0];
          9'h007:  w7_r <= hwdata[15:0];
          9'h0FF:  w255_r <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  //----------------------------------------
  // command execution
  //----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r  <= config_overlay_pkg::ST_IDLE;
      mw_r     <= `MW_RESET;
      udma_r   <= `UDMA_RESET;
      feat_r   <= `FEAT_RESET;
      lba_r    <= `NATIVE_MAX;
      abort_r  <= 1'b0;
      done_r   <= 1'b0;
      cyl_lo_r <= 8'h00;
      cyl_hi_r <= 8'h00;
    end else begin
      unique case (state_r)
        config_overlay_pkg::ST_IDLE: begin
          if (start) begin
            state_r <= config_overlay_pkg::ST_CHECK;
            done_r  <= 1'b0;
            abort_r <= 1'b0;
          end
        end
        config_overlay_pkg::ST_CHECK: begin
          state_r  <= config_overlay_pkg::ST_IDLE;
          done_r   <= 1'b1;
          abort_r  <= bad;
          cyl_lo_r <= rep_loc ? off_bit : 8'h00;
          cyl_hi_r <= rep_loc ? off_word : 8'h00;
          if (!bad) begin
            mw_r   <= new_mw;
            udma_r <= new_ud;
            feat_r <= new_ft;
            lba_r  <= wlba_r;
          end
        end
      endcase
    end
  end

  //----------------------------------------
  // assertions
  //----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_rev_abort:   assert property (checking && w0_r != `DCO_REV |=> abort_r)
    else $error("bad revision not aborted");
  a_mw0_kept:    assert property (mw_r[0])
    else $error("mwdma mode 0 support lost");
  a_mw2_sel:     assert property (checking && clr1[2] && mw_sel_v && mw_sel == 2'h2
                                  |=> abort_r && mw_r[2])
    else $error("selected mwdma 2 removed");
  a_udma_order:  assert property (((udma_r + 6'h01) & udma_r) == 6'h00)
    else $error("udma support has a gap");
  a_hpa_lba:     assert property (checking && hpa && lba_chg
                                  |=> abort_r && lba_r == $past(lba_r))
    else $error("lba changed with protected area");
  a_smart_dep:   assert property (!feat_r[0] |-> feat_r[2:1] == 2'h0)
    else $error("smart removed with sub-features");
  a_gate_abort:  assert property (checking && gate_bad |=> abort_r && cyl_hi_r == 8'h00)
    else $error("frozen or unsupported not aborted");
  a_cyl_zero:    assert property (done_r && !abort_r
                                  |-> cyl_lo_r == 8'h00 && cyl_hi_r == 8'h00)
    else $error("location registers not zero");
  a_no_apply:    assert property (checking && bad |=> $stable(feat_r) && $stable(udma_r)
                                  && $stable(mw_r))
    else $error("aborted overlay applied");
  a_sum_abort:   assert property (checking && sum_r != 8'h00 |=> abort_r ##1 !checking)
    else $error("bad checksum accepted");

  a_mw1_order:   assert property (!mw_r[1] |-> !mw_r[2])
    else $error("mwdma mode 1 removed before mode 2");
  a_udma_sel:    assert property (checking && clr2[3] && ud_sel_v && ud_sel >= 3'h3
                                  |=> abort_r && udma_r[3])
    else $error("selected udma mode removed");
  a_sig_abort:   assert property (checking && w255_r[7:0] != `DCO_SIG
                                  |=> abort_r)
    else $error("bad signature accepted");
  a_lba_apply:   assert property (checking && !bad
                                  |=> !abort_r && lba_r == $past(wlba_r))
    else $error("max lba not applied");
  a_lba_limit:   assert property (checking && wlba_r > `NATIVE_MAX |=> abort_r)
    else $error("lba beyond native maximum accepted");
  // refused clears keep the support bit
  a_hpa_feat:    assert property (checking && hpa && clr7[7] |=> abort_r && feat_r[7])
    else $error("protected area support removed while established");
  a_jumper_feat: assert property (checking && jumper && clr7[4] |=> abort_r && feat_r[4])
    else $error("standby support removed while jumpered");
  a_sec_feat:    assert property (checking && sec_en && clr7[3] |=> abort_r && feat_r[3])
    else $error("security support removed while enabled");
  a_smart_on:    assert property (checking && smart_en && clr7[0]
                                  |=> abort_r && feat_r[0])
    else $error("smart removed while enabled");
  a_no_regrow:   assert property (checking |=> (feat_r & ~$past(feat_r)) == 9'h000)
    else $error("support bit set again");
  a_loc_report:  assert property (checking && rep_loc |=> abort_r && cyl_hi_r != 8'h00)
    else $error("illegal bit location not reported");
  a_fmt_loc:     assert property (checking && fmt_bad
                                  |=> abort_r && cyl_lo_r == 8'h00 && cyl_hi_r == 8'h00)
    else $error("format abort reports a location");
  a_cmd_latency: assert property (start |=> checking ##1 (done_r && !checking))
    else $error("command did not finish in two cycles");
  a_ptr_limit:   assert property (idx_r <= `WORD_COUNT)
    else $error("overlay pointer past last word");

  // main command outcomes
  c_apply_ok:    cover property (checking && !bad ##1 done_r && !abort_r);
  c_illegal_bit: cover property (checking && rep_loc ##1 cyl_hi_r != 8'h00);
  c_format_bad:  cover property (checking && fmt_bad && !gate_bad);
  c_udma_sel:    cover property (checking && ud_sel_v && clr2 != 6'h00);
  c_hpa_lba:     cover property (checking && hpa && lba_chg ##1 abort_r);
endmodule : config_overlay_checker

// File: config_overlay_defs.svh
// Behaviour
// - overlay word 0 must be revision 0001h
// - mwdma word reserved 15:3; bit 0 never cleared
// - mwdma mode 2 clear illegal while selected
// - mwdma mode 1 clear needs mode 2 gone
// - udma bits 5:0 clear identify word 88 bits
// - udma clear needs higher modes gone, unselected
// - words 3-5 set max lba, capacity words
// - protected area established: keep lba, abort
// - feature bit 8 clear removes 48-bit addressing
// - feature bit 7 clear removes protected area
// - feature bit 6 clear removes acoustic management
// - feature bit 5 clear removes queued dma
// - feature bit 4 clear, refused if jumpered
// - feature bit 3 clear, refused if security enabled
// - feature bits 2,1 clear smart log, self-test
// - feature bit 0 clear needs bits 2,1 clear
// - final word: signature low, checksum high
// - all overlay bytes must sum to zero
// - set bit not currently reported is ignored
// - unsupported or frozen: abort, set flag
// - illegal bit: bit, word in cyl registers
`ifndef CONFIG_OVERLAY_DEFS_SVH
`define CONFIG_OVERLAY_DEFS_SVH
//----------------------------------------
// register byte offsets
//----------------------------------------
`define OFF_CTRL     8'h00
`define OFF_DATA     8'h04
`define OFF_STATUS   8'h08
`define OFF_CFG      8'h0C
`define OFF_ID63     8'h20
`define OFF_ID82_85  8'h24
`define OFF_ID83_86  8'h28
`define OFF_ID84_87  8'h2C
`define OFF_ID88_94  8'h30
`define OFF_LBA_LO   8'h34
`define OFF_LBA_HI   8'h38
`define OFF_LBA28    8'h3C
`define OFF_REV      8'h40
//----------------------------------------
// fields and values
//----------------------------------------
`define CTRL_START   0
`define CTRL_REWIND  1
`define CFG_SUPP     0
`define CFG_FREEZE   1
`define CFG_HPA      2
`define CFG_JUMPER   3
`define CFG_SEC      4
`define CFG_SMART    5
`define CFG_MWSEL_V  6
`define CFG_UDSEL_V  7
`define CFG_RESET    32'h0000_0001
`define DCO_REV      16'h0001
`define DCO_SIG      8'hA5
`define WORD_COUNT   9'h100
`define MW_RESET     3'h7
`define UDMA_RESET   6'h3F
`define FEAT_RESET   9'h1FF
`define NATIVE_MAX   48'h0000_0FFF_FFFF
`define LBA28_MAX    48'h0000_0FFF_FFFF
`define ID94_VAL     16'h8080
`endif

// File: config_overlay_pkg.sv
package config_overlay_pkg;
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_CHECK = 1'b1
  } state_e;
endpackage : config_overlay_pkg

// File: overlay_host_model.sv
`timescale 1ns/1ps
`include "config_overlay_defs.svh"
module overlay_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  logic [15:0] ov [256];
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // ----------------------------------------
  // single word transfer
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
  // ----------------------------------------
  // overlay upload with integrity word
  // ----------------------------------------
  task automatic send(input logic [15:0] rev, input logic [15:0] w1, input logic [15:0] w2,
                      input logic [15:0] w7, input logic [47:0] lba, input logic [7:0] sig,
                      input logic [7:0] cadj);
    logic [7:0]  s;
    logic [31:0] q;
    foreach (ov[i]) ov[i] = 16'h0;
    ov[0] = rev;
    ov[1] = w1;
    ov[2] = w2;
    ov[3] = lba[15:0];
    ov[4] = lba[31:16];
    ov[5] = lba[47:32];
    ov[7] = w7;
    s = sig;
    for (int i = 0; i < 255; i++) s = s + ov[i][7:0] + ov[i][15:8];
    ov[255] = {8'h0 - s + cadj, sig};
    for (int i = 0; i < 256; i++) xfer(1'b1, `OFF_DATA, {16'h0, ov[i]}, q);
  endtask : send
endmodule : overlay_host_model

// File: tb_config_overlay_checker.sv
`timescale 1ns/1ps
`include "config_overlay_defs.svh"
module tb_config_overlay_checker;
  localparam logic [47:0] L = `NATIVE_MAX;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, command_aborted_flag;
  logic [31:0] haddr, hwdata, hrdata, q, st;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          n_fail, tests_run;
  logic [7:0]  ra [8] = '{`OFF_ID63, `OFF_ID82_85, `OFF_ID83_86, `OFF_ID84_87,
                          `OFF_ID88_94, `OFF_LBA_LO, `OFF_LBA_HI, `OFF_LBA28};
  logic [31:0] ev [4][8] = '{
    '{32'h7, 32'h0403_0403, 32'h0562_0762, 32'h3_0003, 32'h8080_003F, 32'h0FFF_FFFF, 0,
      32'h0FFF_FFFF},
    '{32'h3, 32'h0403_0403, 32'h0560_0560, 32'h3_0003, 32'hF, 32'h1000, 0, 32'h1000},
    '{32'h3, 32'h0403_0403, 32'h0560_0560, 32'h3_0003, 32'hF, 32'h1000, 0, 32'h1000},
    '{32'h3, 0, 0, 0, 32'hF, 0, 0, 32'h1000}};

  config_overlay_checker dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .command_aborted_flag);
  overlay_host_model host (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata);

  always #5 hclk = ~hclk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic run(input logic [15:0] c, w1, w2, w7, input logic [47:0] lba,
                     input logic [15:0] r, input logic [7:0] s, k);
    wr(`OFF_CFG, {16'h0, c});
    wr(`OFF_CTRL, 32'h2);
    host.send(r, w1, w2, w7, lba, s, k);
    wr(`OFF_CTRL, 32'h1);
    repeat (50) begin
      rd(`OFF_STATUS);
      st = q;
      if (st[1] === 1'b1) break;
    end
  endtask : run
  task automatic bad(input logic [15:0] cyl, c, w7 = 16'h1FF, w1 = 16'h7, w2 = 16'h3F,
                     input logic [47:0] lba = L, input logic [15:0] r = 16'h1,
                     input logic [7:0] s = 8'hA5, k = 8'h0);
    run(c, w1, w2, w7, lba, r, s, k);
    check({8'h0, st[23:0]}, {8'h0, cyl, 8'h06});
    check({31'h0, command_aborted_flag}, 32'h1);
    rd(`OFF_ID63);
    check(q, 32'h7);
    rd(`OFF_LBA28);
    check(q, 32'h0FFF_FFFF);
  endtask : bad
  task automatic good(input logic [15:0] w1, w2, w7, input int row);
    run(16'h1, w1, w2, w7, 48'h1000, 16'h1, 8'hA5, 8'h0);
    check({8'h0, st[23:0]}, 32'h2);
    check({31'h0, command_aborted_flag}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rd(ra[i]);
      check(q, ev[row][i]);
    end
  endtask : good
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    n_fail = 0;
    tests_run = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i]);
      check(q, ev[0][i]);
    end
    rd(`OFF_REV);
    check(q, {16'h0, `DCO_REV});
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80);
    check(q, 32'h0);
    check({31'h0, hresp}, 32'h0);
    bad(16'h0000, 16'h0000);
    bad(16'h0000, 16'h0003);
    bad(16'h0000, 16'h0001, 16'h1FF, 16'h7, 16'h3F, L, 16'h2);
    bad(16'h0000, 16'h0001, 16'h1FF, 16'h7, 16'h3F, L, 16'h1, 8'h5A);
    bad(16'h0000, 16'h0001, 16'h1FF, 16'h7, 16'h3F, L, 16'h1, 8'hA5, 8'h01);
    bad(16'h0100, 16'h0001, 16'h1DF, 16'h6);
    bad(16'h0102, 16'h0241, 16'h1FF, 16'h3);
    bad(16'h0101, 16'h0001, 16'h1FF, 16'h5);
    bad(16'h0203, 16'h3081, 16'h1FF, 16'h7, 16'h37);
    bad(16'h0707, 16'h0005, 16'h17F);
    bad(16'h0704, 16'h0009, 16'h1EF);
    bad(16'h0703, 16'h0011, 16'h1F7);
    bad(16'h0700, 16'h0001, 16'h1FE);
    bad(16'h0700, 16'h0021, 16'h1F8);
    bad(16'h0300, 16'h0005, 16'h1FF, 16'h7, 16'h3F, 48'h1000);
    bad(16'h0300, 16'h0001, 16'h1FF, 16'h7, 16'h3F, 48'h1000_0000);
    good(16'h3, 16'hF, 16'h19F, 1);
    good(16'h7, 16'h3F, 16'h19F, 2);
    good(16'h3, 16'hF, 16'h0, 3);
    report_and_stop();
  end
  initial begin
    #500us;
    n_fail++;
    report_and_stop();
  end
endmodule : tb_config_overlay_checker
